// [sdm_pkg.sv]
package sdm_pkg;

  // ----------------------------------------------------------------------
  // input code: signed, full scale +/-80 mV maps to +/-32768 (vin/160mV*65536)
  // ----------------------------------------------------------------------
  localparam int                      IN_W      = 18;
  localparam int                      CODE_W    = 16;
  localparam logic signed [IN_W-1:0]  POS_FS    = 18'sh08000;
  localparam logic signed [IN_W-1:0]  NEG_FS    = 18'sh38000;
  localparam logic signed [IN_W:0]    MID_OFS   = 19'sh08000;
  localparam logic signed [IN_W:0]    DENS_TOP  = 19'sh10000;
  localparam logic [CODE_W:0]         DENS_MAX  = 17'h10000;
  localparam logic [CODE_W:0]         DENS_MIN  = 17'h00000;

  // ----------------------------------------------------------------------
  // density window and link watchdog timing
  // ----------------------------------------------------------------------
  localparam int                      WIN_LEN       = 256;
  localparam int                      CLK_MHZ       = 125;
  localparam int                      LINK_LOSS_NS  = 1000;
  localparam int                      LINK_LOSS_CYC = (LINK_LOSS_NS * CLK_MHZ + 999) / 1000;
  localparam int                      WD_W          = 10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_LOST = 2'b10
  } mod_state_e;

endpackage : sdm_pkg

// [sdm_accum.sv]
`timescale 1ns/1ps
`default_nettype none

// first-order error-feedback accumulator: carry density equals dens/2^CODE_W
module sdm_accum #(
  parameter int CODE_W = 16
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // step and density
  input  wire logic              step,
  input  wire logic [CODE_W:0]   dens,
  // next bit
  output logic                   bit_next
);

  logic [CODE_W-1:0] acc_reg;
  logic [CODE_W+1:0] sum;

  assign sum      = {2'b00, acc_reg} + {1'b0, dens};
  assign bit_next = |sum[CODE_W+1:CODE_W];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= '0;
    end else if (step) begin
      acc_reg <= sum[CODE_W-1:0];
    end
  end

endmodule : sdm_accum
`default_nettype wire

// [sdm_bitstream.sv]
// Function
// - zero input gives half ones
// - +/-50 mV gives 81.25/18.75 percent ones
// - at or beyond full scale, all ones/zeros
// - ones density equals vin/160mV plus half
`timescale 1ns/1ps
`default_nettype none

module sdm_bitstream
  import sdm_pkg::*;
#(
  parameter int WIN = sdm_pkg::WIN_LEN
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            rstn,
  // sampled input
  input  wire logic signed [sdm_pkg::IN_W-1:0] vin_code,
  input  wire logic                            mod_en,
  // link
  input  wire logic                            mclk_in,
  output logic                                 mod_data,
  // status
  output logic                                 bit_strobe,
  output logic                                 over_range,
  output logic                                 link_lost,
  output logic [$clog2(WIN+1)-1:0]             ones_count,
  output logic                                 count_valid
);
  import sdm_pkg::*;

  localparam int CNT_W = $clog2(WIN+1);
  localparam int POS_W = $clog2(WIN);
  localparam logic [POS_W-1:0] WIN_LAST   = POS_W'(WIN - 1);
  localparam logic [WD_W-1:0]  WD_LIMIT   = WD_W'(LINK_LOSS_CYC);

  // ----------------------------------------------------------------------
  // link clock synchroniser and edge detect
  // ----------------------------------------------------------------------
  logic mclk_s1_reg;
  logic mclk_s2_reg;
  logic mclk_s3_reg;
  wire  mclk_rise = mclk_s2_reg & ~mclk_s3_reg;

  // two-flop synchroniser; only the second flop feeds logic
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
    end else begin
      mclk_s1_reg <= mclk_in;
      mclk_s2_reg <= mclk_s1_reg;
    end
  end

  // delayed copy for edge detect, resets to the idle low level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mclk_s3_reg <= 1'b0;
    end else begin
      mclk_s3_reg <= mclk_s2_reg;
    end
  end

  // ----------------------------------------------------------------------
  // input to density: vin + half scale, clamped to 0..2^16
  // ----------------------------------------------------------------------
  wire logic signed [IN_W:0] shifted = {vin_code[IN_W-1], vin_code} + MID_OFS;
  wire below_fs = shifted[IN_W];
  wire above_fs = !shifted[IN_W] && (shifted > DENS_TOP);
  wire logic [CODE_W:0] dens = below_fs ? DENS_MIN :
                               above_fs ? DENS_MAX :
                               shifted[CODE_W:0];

  // ----------------------------------------------------------------------
  // range flag: input at or beyond either full-scale limit
  // ----------------------------------------------------------------------
  wire at_pos_fs = (vin_code >= POS_FS);
  wire at_neg_fs = (vin_code <= NEG_FS);
  wire at_fs     = at_pos_fs || at_neg_fs;

  // ----------------------------------------------------------------------
  // state machine: idle, running, link lost
  // ----------------------------------------------------------------------
  mod_state_e      state_reg;
  mod_state_e      state_next;
  logic [WD_W-1:0] wd_reg;
  wire             wd_expired = (wd_reg == WD_LIMIT);
  wire             step = mclk_rise && mod_en;
  wire             in_run    = (state_reg == ST_RUN);
  wire             lost_next = (state_next == ST_LOST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (step) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!mod_en) state_next = ST_IDLE;
        else if (wd_expired) state_next = ST_LOST;
      end
      ST_LOST: begin
        if (!mod_en) state_next = ST_IDLE;
        else if (step) state_next = ST_RUN;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // link watchdog: cycles since the last link clock rise
  // ----------------------------------------------------------------------
  wire wd_clear = mclk_rise || !in_run;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_reg <= '0;
    end else if (wd_clear) begin
      wd_reg <= '0;
    end else if (!wd_expired) begin
      wd_reg <= wd_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // modulator core
  // ----------------------------------------------------------------------
  logic bit_next;

  sdm_accum #(
    .CODE_W   (CODE_W)
  ) u_accum (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .step     (step),
    .dens     (dens),
    .bit_next (bit_next)
  );

  // ----------------------------------------------------------------------
  // output bit, one new bit per link clock rising edge
  // ----------------------------------------------------------------------
  logic mod_data_reg;
  logic bit_strobe_reg;
  logic over_range_reg;
  logic link_lost_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mod_data_reg   <= 1'b0;
      over_range_reg <= 1'b0;
    end else if (step) begin
      mod_data_reg   <= bit_next;
      over_range_reg <= at_fs;
    end
  end

  // strobe and link status are refreshed every cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_strobe_reg <= 1'b0;
      link_lost_reg  <= 1'b0;
    end else begin
      bit_strobe_reg <= step;
      link_lost_reg  <= lost_next;
    end
  end

  // ----------------------------------------------------------------------
  // ones per window of WIN bits, as a density monitor
  // ----------------------------------------------------------------------
  logic [POS_W-1:0] pos_reg;
  logic [CNT_W-1:0] acc_ones_reg;
  logic [CNT_W-1:0] ones_count_reg;
  logic             count_valid_reg;
  wire              win_end = step && (pos_reg == WIN_LAST);
  wire [CNT_W-1:0]  ones_inc = acc_ones_reg + CNT_W'(bit_next);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pos_reg      <= '0;
      acc_ones_reg <= '0;
    end else if (step) begin
      pos_reg      <= win_end ? '0 : pos_reg + 1'b1;
      acc_ones_reg <= win_end ? '0 : ones_inc;
    end
  end

  // ----------------------------------------------------------------------
  // publish the finished window count with a one-cycle valid pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ones_count_reg  <= '0;
      count_valid_reg <= 1'b0;
    end else begin
      count_valid_reg <= win_end;
      if (win_end) begin
        ones_count_reg <= ones_inc;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign mod_data    = mod_data_reg;
  assign bit_strobe  = bit_strobe_reg;
  assign over_range  = over_range_reg;
  assign link_lost   = link_lost_reg;
  assign ones_count  = ones_count_reg;
  assign count_valid = count_valid_reg;

endmodule : sdm_bitstream
`default_nettype wire

// [sdm_filter_model.sv]
`timescale 1ns/1ps
`default_nettype none
// decimating counter standing in for the far-side filter
module sdm_filter_model #(
  parameter int WIN = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        mod_data,
  input  wire logic        bit_strobe,
  output logic [15:0]      code,
  output logic             code_valid
);
  int ones, n, full;
  assign full = (ones + mod_data) * 65536 / WIN;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ones <= 0;
      n <= 0;
      code <= 16'h0000;
      code_valid <= 1'b0;
    end else begin
      code_valid <= 1'b0;
      if (bit_strobe && n == WIN - 1) begin
        code <= (full > 65535) ? 16'hFFFF : 16'(full);
        code_valid <= 1'b1;
        ones <= 0;
        n <= 0;
      end else if (bit_strobe) begin
        ones <= ones + mod_data;
        n <= n + 1;
      end
    end
  end
endmodule : sdm_filter_model
`default_nettype wire

// [sdm_bitstream_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sdm_bitstream_monitor
  import sdm_pkg::*;
#(
  parameter int WIN = sdm_pkg::WIN_LEN
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rstn,
  input  wire logic signed [sdm_pkg::IN_W-1:0] vin_code,
  input  wire logic                            mod_en,
  input  wire logic                            mclk_in,
  input  wire logic                            mod_data,
  input  wire logic                            bit_strobe,
  input  wire logic                            over_range,
  input  wire logic                            link_lost,
  input  wire logic [$clog2(WIN+1)-1:0]        ones_count,
  input  wire logic                            count_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_strobe_pulse: assert property (bit_strobe |=> !bit_strobe) else $error("long strobe");
  a_data_stable: assert property (!bit_strobe |-> $stable(mod_data)) else $error("data moved");
  a_refuse_off: assert property (!mod_en |=> !bit_strobe) else $error("bit while off");
  a_strobe_cause: assert property (bit_strobe |-> $past(mclk_in, 3) && !$past(mclk_in, 4))
    else $error("strobe without rise");
  a_valid_with_bit: assert property (count_valid |-> bit_strobe) else $error("stray valid");
  a_count_range: assert property (ones_count <= WIN) else $error("count too big");
  a_full_ones: assert property (bit_strobe && $past(vin_code) >= POS_FS |-> mod_data)
    else $error("zero above full scale");
  a_full_zeros: assert property (bit_strobe && $past(vin_code) <= NEG_FS |-> !mod_data)
    else $error("one below full scale");
  a_over_flag: assert property (bit_strobe |-> over_range ==
    ($past(vin_code) >= POS_FS || $past(vin_code) <= NEG_FS)) else $error("bad range flag");
  c_valid: cover property (count_valid);
  c_over: cover property (over_range);
  c_lost: cover property (link_lost);
endmodule : sdm_bitstream_monitor
bind sdm_bitstream sdm_bitstream_monitor #(.WIN(WIN)) mon_u (.ref_clk(ref_clk), .rstn(rstn),
  .vin_code(vin_code), .mod_en(mod_en), .mclk_in(mclk_in), .mod_data(mod_data),
  .bit_strobe(bit_strobe), .over_range(over_range), .link_lost(link_lost),
  .ones_count(ones_count), .count_valid(count_valid));
`default_nettype wire

// [sdm_bitstream_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t %s", $time, m); end end
module sdm_bitstream_tb_top;
  import sdm_pkg::*;
  localparam int WIN = 16;
  logic ref_clk = 0, rstn = 0, mod_en = 0, mclk_in = 0, run = 0;
  logic signed [IN_W-1:0] vin_code = '0;
  logic mod_data, bit_strobe, over_range, link_lost, count_valid, code_valid;
  logic [$clog2(WIN+1)-1:0] ones_count;
  logic [15:0] code;
  int fail_count = 0, compares = 0, cyc = 0, ph = 0, n, v;
  int seed = 32'h57DC93A2;
  int corner[7] = '{0, 20480, -20480, 32768, -32768, 40000, -40000};
  sdm_bitstream #(.WIN(WIN)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .vin_code(vin_code),
    .mod_en(mod_en), .mclk_in(mclk_in), .mod_data(mod_data), .bit_strobe(bit_strobe),
    .over_range(over_range), .link_lost(link_lost), .ones_count(ones_count),
    .count_valid(count_valid));
  sdm_filter_model #(.WIN(WIN)) filt_u (.ref_clk(ref_clk), .rstn(rstn), .mod_data(mod_data),
    .bit_strobe(bit_strobe), .code(code), .code_valid(code_valid));
  initial forever #4 ref_clk = ~ref_clk;
  // link clock: 10 ref cycles a bit, still while run is low
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
    ph = run ? (ph + 1) % 10 : 0;
    mclk_in <= run && ph >= 5;
  end
  function automatic int exp_ones(int x);
    int d;
    d = x + 32768;
    d = d < 0 ? 0 : (d > 65536 ? 65536 : d);
    return d * WIN / 65536;
  endfunction : exp_ones
  task automatic apply(int x);
    int e;
    e = exp_ones(x) * 65536 / WIN;
    @(posedge ref_clk) vin_code <= IN_W'(x);
    repeat (2) do @(negedge ref_clk); while (count_valid !== 1'b1);
    `CHK(ones_count, ($clog2(WIN+1))'(exp_ones(x)), "ones count")
    `CHK(over_range, 1'(x >= 32768 || x <= -32768), "range flag")
    @(negedge ref_clk);
    `CHK(code_valid, 1'b1, "no filter word")
    `CHK(code, 16'(e > 65535 ? 65535 : e), "filter code")
    $display("test vin %0d done", x);
  endtask : apply
  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    mod_en <= 1'b1;
    run <= 1'b1;
    foreach (corner[i]) apply(corner[i]);
    repeat (6) begin
      v = ($random(seed) % 9) * 4096;
      apply(v);
    end
    @(posedge ref_clk) mod_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
    n = 0;
    repeat (100) @(negedge ref_clk) n += bit_strobe;
    `CHK(n, 0, "bit while disabled")
    $display("test disable done");
    @(posedge ref_clk) mod_en <= 1'b1;
    repeat (30) @(posedge ref_clk);
    run <= 1'b0;
    repeat (140) @(negedge ref_clk);
    `CHK(link_lost, 1'b1, "loss not flagged")
    run <= 1'b1;
    repeat (30) @(negedge ref_clk);
    `CHK(link_lost, 1'b0, "loss not cleared")
    $display("test link done");
    results();
  end
endmodule : sdm_bitstream_tb_top
`default_nettype wire
